// >>> verilog/hub_config_register_slice.sv
// Notes on behaviour
// - Bit 7 of the first configuration byte picks bus power at 0 and self power at 1.
// - With dynamic switching on, the power mode follows the local power sense pin instead.
// - Bit 5 of the first configuration byte at 1 removes high speed, leaving full speed only.
// - First byte bit 3 at 1 drops end of packet at the first frame end point in full speed.
// - Bits 2:1 of the first byte choose ganged sensing at 00, reserved at 01, none at 1x.
// - Second byte bit 7 lets the hub fall to bus power when local power goes, and return.
// - Bits 5:4 of the second byte choose an over-current delay of 0.1, 2, 4 or 6 ms.
// - Bit 3 of the second byte marks the hub as part of a compound device.
// - Bits 1 and 2 of the fixed port mask mark ports 1 and 2 non-removable; others read zero.
// - In self power, port off mask bits 1 and 2 disable ports 1 and 2; others read zero.
// - Offset 06h holds all eight bits of the high byte of the device release number.
// - Writing 1 to bit 2 of offset 00h restores the defaults of offsets 06h..0Ah, but not lock or attach, and the bit self-clears.
`timescale 1ns/1ps
module hub_config_register_slice
   import hub_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = DELAY_TICK_CYCLES
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic local_power_sense_pin,
   input wire logic overcurrent_n_pin,
   output hub_config_t hub_config,
   output logic config_lock,
   output logic usb_attach,
   output logic soft_reset_pulse,
   output logic overcurrent_fault
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [7:0] device_release_high_byte_reg;
   logic [7:0] power_speed_config_a_reg;
   logic [7:0] power_switch_config_b_reg;
   logic [7:0] fixed_port_mask_reg;
   logic [7:0] self_powered_port_off_mask_reg;
   logic config_lock_reg;
   logic usb_attach_reg;
   logic soft_reset_reg;
   logic cfg_write;
   logic local_power_present;
   logic overcurrent_seen;
   logic self_powered;
   logic sense_enable;
   hub_config_t hub_config_next;
   logic status_write;
   logic wr_release;
   logic wr_power_a;
   logic wr_power_b;
   logic wr_fixed_port;
   logic wr_port_off;
   logic [7:0] status_byte;
   logic [7:0] rdata_next;
   logic overcurrent_pin_active;
   logic sense_active;
   logic [1:0] delay_select;
   logic [2:1] port_off_active;

   // Locked range covers 01h..10h; offset 00h stays writable
   ////////////////////////////////////////////////////////////////////////////////
   // Write decode

   assign cfg_write = reg_write && !config_lock_reg && !soft_reset_reg
      && (reg_addr >= OFS_PROT_LOW) && (reg_addr <= OFS_PROT_HIGH);

   // One strobe per register keeps each storage process to its own decode
   assign wr_release = cfg_write && (reg_addr == OFS_DEVICE_RELEASE_HIGH);
   assign wr_power_a = cfg_write && (reg_addr == OFS_POWER_SPEED_A);
   assign wr_power_b = cfg_write && (reg_addr == OFS_POWER_SWITCH_B);
   assign wr_fixed_port = cfg_write && (reg_addr == OFS_FIXED_PORT);
   assign wr_port_off = cfg_write && (reg_addr == OFS_PORT_OFF_SELF);

   // Status/command stays writable under the lock so attach can still be given
   assign status_write = reg_write && (reg_addr == OFS_STATUS_CMD);

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         device_release_high_byte_reg <= RST_DEVICE_RELEASE_HIGH;
      else if (soft_reset_reg)
         device_release_high_byte_reg <= RST_DEVICE_RELEASE_HIGH;
      else if (wr_release)
         device_release_high_byte_reg <= reg_wdata;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         power_speed_config_a_reg <= RST_POWER_SPEED_A;
      else if (soft_reset_reg)
         power_speed_config_a_reg <= RST_POWER_SPEED_A;
      else if (wr_power_a)
         power_speed_config_a_reg <= reg_wdata & MASK_POWER_SPEED_A;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         power_switch_config_b_reg <= RST_POWER_SWITCH_B;
      else if (soft_reset_reg)
         power_switch_config_b_reg <= RST_POWER_SWITCH_B;
      else if (wr_power_b)
         power_switch_config_b_reg <= reg_wdata & MASK_POWER_SWITCH_B;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         fixed_port_mask_reg <= RST_FIXED_PORT;
      else if (soft_reset_reg)
         fixed_port_mask_reg <= RST_FIXED_PORT;
      else if (wr_fixed_port)
         fixed_port_mask_reg <= reg_wdata & MASK_PORT;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         self_powered_port_off_mask_reg <= RST_PORT_OFF_SELF;
      else if (soft_reset_reg)
         self_powered_port_off_mask_reg <= RST_PORT_OFF_SELF;
      else if (wr_port_off)
         self_powered_port_off_mask_reg <= reg_wdata & MASK_PORT;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status/command: lock and attach are write-once, cleared only by the reset pin

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         config_lock_reg <= RST_STATUS_CMD[BIT_CONFIG_LOCK];
      else if (status_write && reg_wdata[BIT_CONFIG_LOCK])
         config_lock_reg <= 1'b1;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         usb_attach_reg <= RST_STATUS_CMD[BIT_USB_ATTACH];
      else if (status_write && reg_wdata[BIT_USB_ATTACH])
         usb_attach_reg <= 1'b1;
   end

   // Held for one cycle only, so the clear of the storage is a single pulse
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         soft_reset_reg <= RST_STATUS_CMD[BIT_SOFT_RESET];
      else if (soft_reset_reg)
         soft_reset_reg <= 1'b0;
      else if (status_write && reg_wdata[BIT_SOFT_RESET])
         soft_reset_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port: one cycle latency, unmapped offsets read zero

   assign status_byte = {5'h00, soft_reset_reg, config_lock_reg, usb_attach_reg};

   always_comb
   begin
      case (reg_addr)
         OFS_STATUS_CMD: rdata_next = status_byte;
         OFS_DEVICE_RELEASE_HIGH: rdata_next = device_release_high_byte_reg;
         OFS_POWER_SPEED_A: rdata_next = power_speed_config_a_reg;
         OFS_POWER_SWITCH_B: rdata_next = power_switch_config_b_reg;
         OFS_FIXED_PORT: rdata_next = fixed_port_mask_reg;
         OFS_PORT_OFF_SELF: rdata_next = self_powered_port_off_mask_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Data holds between reads so a slow host may collect it late
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= rdata_next;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         reg_rvalid <= 1'b0;
      else
         reg_rvalid <= reg_read;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs

   pin_sync3 power_sense_sync
   (
      .mclk(mclk),
      .reset(reset),
      .pin_in(local_power_sense_pin),
      .level_out(local_power_present)
   );

   // Inverted ahead of the synchroniser so its reset level matches an idle pin
   assign overcurrent_pin_active = !overcurrent_n_pin;

   pin_sync3 overcurrent_sync
   (
      .mclk(mclk),
      .reset(reset),
      .pin_in(overcurrent_pin_active),
      .level_out(overcurrent_seen)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   // Dynamic switching overrides the stored mode with the sensed supply
   always_comb
   begin
      if (power_switch_config_b_reg[BIT_DYNAMIC_SWITCH])
         self_powered = local_power_present;
      else
         self_powered = power_speed_config_a_reg[BIT_POWER_SOURCE];
   end

   // Reserved code 01 is handled as ganged so sensing is never silently lost
   assign sense_enable =
      !power_speed_config_a_reg[BIT_SENSE_MODE_HI];

   // Mask applies only while self powered; with two ports any choice is contiguous
   always_comb
   begin
      if (self_powered)
         port_off_active = self_powered_port_off_mask_reg[BIT_PORT2:BIT_PORT1];
      else
         port_off_active = 2'b00;
   end

   assign delay_select = power_switch_config_b_reg[BIT_DELAY_SEL_HI:BIT_DELAY_SEL_LO];

   always_comb
   begin
      hub_config_next = '0;
      hub_config_next.self_powered = self_powered;
      hub_config_next.full_speed_only = power_speed_config_a_reg[BIT_FULL_SPEED_ONLY];
      hub_config_next.end_packet_suppress =
         power_speed_config_a_reg[BIT_END_PACKET_SUPPRESS];
      hub_config_next.overcurrent_sense_mode = sense_mode_t'(
         power_speed_config_a_reg[BIT_SENSE_MODE_HI:BIT_SENSE_MODE_LO]);
      hub_config_next.overcurrent_sense_enable = sense_enable;
      hub_config_next.overcurrent_delay_select = delay_select;
      hub_config_next.compound_device = power_switch_config_b_reg[BIT_COMPOUND];
      hub_config_next.fixed_port_flags =
         fixed_port_mask_reg[BIT_PORT2:BIT_PORT1];
      hub_config_next.self_powered_port_off = port_off_active;
      hub_config_next.device_release_high = device_release_high_byte_reg;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         hub_config <= '0;
      else
         hub_config <= hub_config_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Over-current qualification

   // Sensing off keeps the timer cleared so no stale count survives a mode change
   assign sense_active = overcurrent_seen && sense_enable;

   overcurrent_delay #(.TICK_CYCLES(TICK_CYCLES)) oc_delay
   (
      .mclk(mclk),
      .reset(reset),
      .sense_active(sense_active),
      .delay_select(delay_select),
      .fault(overcurrent_fault)
   );

   assign config_lock = config_lock_reg;
   assign usb_attach = usb_attach_reg;
   assign soft_reset_pulse = soft_reset_reg;

endmodule

// >>> verilog/hub_cfg_pkg.sv
package hub_cfg_pkg;

   // Register offsets on the configuration port
   localparam logic [7:0] OFS_STATUS_CMD = 8'h00;
   localparam logic [7:0] OFS_PROT_LOW = 8'h01;
   localparam logic [7:0] OFS_PROT_HIGH = 8'h10;
   localparam logic [7:0] OFS_DEVICE_RELEASE_HIGH = 8'h06;
   localparam logic [7:0] OFS_POWER_SPEED_A = 8'h07;
   localparam logic [7:0] OFS_POWER_SWITCH_B = 8'h08;
   localparam logic [7:0] OFS_FIXED_PORT = 8'h09;
   localparam logic [7:0] OFS_PORT_OFF_SELF = 8'h0A;

   // Reset values
   localparam logic [7:0] RST_STATUS_CMD = 8'h00;
   localparam logic [7:0] RST_DEVICE_RELEASE_HIGH = 8'h00;
   localparam logic [7:0] RST_POWER_SPEED_A = 8'h00;
   localparam logic [7:0] RST_POWER_SWITCH_B = 8'h00;
   localparam logic [7:0] RST_FIXED_PORT = 8'h00;
   localparam logic [7:0] RST_PORT_OFF_SELF = 8'h00;

   // Status/command fields
   localparam int BIT_USB_ATTACH = 0;
   localparam int BIT_CONFIG_LOCK = 1;
   localparam int BIT_SOFT_RESET = 2;

   // First configuration byte fields
   localparam int BIT_POWER_SOURCE = 7;
   localparam int BIT_FULL_SPEED_ONLY = 5;
   localparam int BIT_END_PACKET_SUPPRESS = 3;
   localparam int BIT_SENSE_MODE_HI = 2;
   localparam int BIT_SENSE_MODE_LO = 1;

   // Second configuration byte fields
   localparam int BIT_DYNAMIC_SWITCH = 7;
   localparam int BIT_DELAY_SEL_HI = 5;
   localparam int BIT_DELAY_SEL_LO = 4;
   localparam int BIT_COMPOUND = 3;

   // Port mask fields
   localparam int BIT_PORT1 = 1;
   localparam int BIT_PORT2 = 2;

   // Writable bits of each register; everything else is reserved
   localparam logic [7:0] MASK_STATUS_CMD = 8'h07;
   localparam logic [7:0] MASK_POWER_SPEED_A = 8'hAE;
   localparam logic [7:0] MASK_POWER_SWITCH_B = 8'hB8;
   localparam logic [7:0] MASK_PORT = 8'h06;

   typedef enum logic [1:0]
   {
      SENSE_GANGED = 2'b00,
      SENSE_RESERVED = 2'b01,
      SENSE_NONE = 2'b10,
      SENSE_NONE_ALT = 2'b11
   } sense_mode_t;

   // Over-current delay figures and tick base
   localparam int CLOCK_PERIOD_PS = 5000;
   localparam int DELAY_TICK_US_X10 = 1;
   localparam int DELAY_0_US_X10 = 1;
   localparam int DELAY_1_US_X10 = 20;
   localparam int DELAY_2_US_X10 = 40;
   localparam int DELAY_3_US_X10 = 60;
   // Tick of 0.1 ms in clock cycles
   localparam int DELAY_TICK_CYCLES = (DELAY_TICK_US_X10 * 100_000_000) / CLOCK_PERIOD_PS;
   localparam logic [6:0] DELAY_0_TICKS = 7'(DELAY_0_US_X10 / DELAY_TICK_US_X10);
   localparam logic [6:0] DELAY_1_TICKS = 7'(DELAY_1_US_X10 / DELAY_TICK_US_X10);
   localparam logic [6:0] DELAY_2_TICKS = 7'(DELAY_2_US_X10 / DELAY_TICK_US_X10);
   localparam logic [6:0] DELAY_3_TICKS = 7'(DELAY_3_US_X10 / DELAY_TICK_US_X10);

   // Decoded configuration handed to the hub core
   typedef struct packed
   {
      logic self_powered;
      logic full_speed_only;
      logic end_packet_suppress;
      sense_mode_t overcurrent_sense_mode;
      logic overcurrent_sense_enable;
      logic [1:0] overcurrent_delay_select;
      logic compound_device;
      logic [2:1] fixed_port_flags;
      logic [2:1] self_powered_port_off;
      logic [7:0] device_release_high;
   } hub_config_t;

endpackage

// >>> verilog/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3
   import hub_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic pin_in,
   output logic level_out
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change is taken only once the second and third stages agree
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         level_out <= 1'b0;
      else if (s2_reg == s3_reg)
         level_out <= s3_reg;
   end

endmodule

// >>> verilog/overcurrent_delay.sv
`timescale 1ns/1ps
module overcurrent_delay
   import hub_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = DELAY_TICK_CYCLES
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sense_active,
   input wire logic [1:0] delay_select,
   output logic fault
);

   logic [31:0] div_reg;
   logic tick;
   logic [6:0] ticks_reg;
   logic [6:0] limit;

   // Divider gives one enable pulse per 0.1 ms
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         div_reg <= 32'h00000000;
      else if (!sense_active || tick)
         div_reg <= 32'h00000000;
      else
         div_reg <= div_reg + 32'h00000001;
   end

   assign tick = sense_active && (div_reg == 32'(TICK_CYCLES - 1));

   always_comb
   begin
      case (delay_select)
         2'b00: limit = DELAY_0_TICKS;
         2'b01: limit = DELAY_1_TICKS;
         2'b10: limit = DELAY_2_TICKS;
         default: limit = DELAY_3_TICKS;
      endcase
   end

   // Condition must persist the whole delay before a fault is flagged
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ticks_reg <= 7'h00;
      else if (!sense_active)
         ticks_reg <= 7'h00;
      else if (tick && ticks_reg != 7'h7F)
         ticks_reg <= ticks_reg + 7'h01;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         fault <= 1'b0;
      else
         fault <= sense_active && (ticks_reg >= limit);
   end

endmodule

// >>> sim/host_loader.sv
`timescale 1ns/1ps
module host_loader
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_write,
   output logic [7:0] reg_wdata,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
      reg_read = 1'b0;
   end
   // Released lines carry the inverse so stale values never pass for live ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge mclk);
      reg_write = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge mclk);
      reg_read = 1'b0;
      reg_addr = ~a;
      @(negedge mclk);
      d = reg_rdata;
   endtask
endmodule

// >>> sim/hub_config_props.sv
`timescale 1ns/1ps
module hub_config_props
   import hub_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = DELAY_TICK_CYCLES
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic local_power_sense_pin,
   input wire logic overcurrent_n_pin,
   input wire hub_config_t hub_config,
   input wire logic config_lock,
   input wire logic usb_attach,
   input wire logic soft_reset_pulse,
   input wire logic overcurrent_fault
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence free_wr(logic [7:0] ofs);
      reg_write && reg_addr == ofs && !config_lock && !soft_reset_pulse;
   endsequence
   a_byte_a_fields: assert property (free_wr(OFS_POWER_SPEED_A) |-> ##2
      {hub_config.full_speed_only, hub_config.end_packet_suppress} == $past({reg_wdata[5],
      reg_wdata[3]}, 2)) else $error("first config byte fields wrong");
   a_byte_b_fields: assert property (free_wr(OFS_POWER_SWITCH_B) |-> ##2
      {hub_config.overcurrent_delay_select, hub_config.compound_device}
      == $past(reg_wdata[5:3], 2)) else $error("second config byte fields wrong");
   a_release_byte: assert property (free_wr(OFS_DEVICE_RELEASE_HIGH) |-> ##2
      hub_config.device_release_high == $past(reg_wdata, 2)) else $error("release byte wrong");
   a_fixed_flags: assert property (free_wr(OFS_FIXED_PORT) |-> ##2
      hub_config.fixed_port_flags == $past(reg_wdata[2:1], 2)) else $error("port flags wrong");
   a_sense_enable: assert property (!$past(reset) |->
      hub_config.overcurrent_sense_enable == !hub_config.overcurrent_sense_mode[1])
      else $error("sense enable does not follow mode");
   a_port_off_bus: assert property (!hub_config.self_powered |->
      hub_config.self_powered_port_off == 2'b00) else $error("port off while bus powered");
   a_lock_sticky: assert property (config_lock |=> config_lock)
      else $error("lock dropped without reset");
   a_soft_clear: assert property (soft_reset_pulse |=> !soft_reset_pulse ##1
      (hub_config.device_release_high == 8'h00 && !hub_config.compound_device))
      else $error("soft reset did not clear");
   a_reserved_zero: assert property (reg_rvalid &&
      $past(reg_addr) == OFS_POWER_SWITCH_B |-> (reg_rdata & ~MASK_POWER_SWITCH_B) == 8'h00)
      else $error("reserved bits read nonzero");
   a_read_valid: assert property (reg_rvalid == $past(reg_read))
      else $error("read valid not one cycle after read strobe");
endmodule

bind hub_config_register_slice hub_config_props #(.TICK_CYCLES(TICK_CYCLES)) i_hub_config_props
(
   .mclk(mclk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_write(reg_write),
   .reg_wdata(reg_wdata),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid),
   .local_power_sense_pin(local_power_sense_pin),
   .overcurrent_n_pin(overcurrent_n_pin),
   .hub_config(hub_config),
   .config_lock(config_lock),
   .usb_attach(usb_attach),
   .soft_reset_pulse(soft_reset_pulse),
   .overcurrent_fault(overcurrent_fault)
);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import hub_cfg_pkg::*;
();
   // Short tick keeps the delay counts within a brief run
   localparam int TICKS = 4;
   logic mclk;
   logic reset;
   logic [7:0] reg_addr;
   logic reg_write;
   logic [7:0] reg_wdata;
   logic reg_read;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic local_power_sense_pin;
   logic overcurrent_n_pin;
   hub_config_t hub_config;
   logic config_lock;
   logic usb_attach;
   logic soft_reset_pulse;
   logic overcurrent_fault;
   logic [7:0] rdat;
   int num_errors = 0;
   int total_checks = 0;

   hub_config_register_slice #(.TICK_CYCLES(TICKS)) i_hub_config_register_slice
   (
      .mclk(mclk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_write(reg_write),
      .reg_wdata(reg_wdata),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .local_power_sense_pin(local_power_sense_pin),
      .overcurrent_n_pin(overcurrent_n_pin),
      .hub_config(hub_config),
      .config_lock(config_lock),
      .usb_attach(usb_attach),
      .soft_reset_pulse(soft_reset_pulse),
      .overcurrent_fault(overcurrent_fault)
   );
   host_loader i_host_loader
   (
      .mclk(mclk),
      .reg_addr(reg_addr),
      .reg_write(reg_write),
      .reg_wdata(reg_wdata),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_host_loader.rd(a, rdat);
      chk(rdat, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #40000;
      num_errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset = 1'b1;
      local_power_sense_pin = 1'b0;
      overcurrent_n_pin = 1'b1;
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      i_host_loader.wr(8'h0B, 8'hFF);
      rchk(8'h0B, 8'h00);
      for (int i = 0; i < 5; i++)
         rchk(OFS_DEVICE_RELEASE_HIGH + 8'(i), 8'h00);
      $display("defaults done");
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'hFF);
      rchk(OFS_POWER_SPEED_A, 8'hAE);
      chk({7'h00, hub_config.self_powered}, 8'h01);
      chk({7'h00, hub_config.full_speed_only}, 8'h01);
      chk({7'h00, hub_config.end_packet_suppress}, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         i_host_loader.wr(OFS_POWER_SPEED_A, 8'(m << 1));
         cyc(1);
         chk({6'h00, hub_config.overcurrent_sense_mode}, 8'(m));
         chk({7'h00, hub_config.overcurrent_sense_enable}, 8'(m < 2));
         i_host_loader.wr(OFS_POWER_SWITCH_B, 8'h47 | 8'(m << 4) | {4'h0, m[0], 3'h0});
         rchk(OFS_POWER_SWITCH_B, 8'(m << 4) | {4'h0, m[0], 3'h0});
         chk({6'h00, hub_config.overcurrent_delay_select}, 8'(m));
         chk({7'h00, hub_config.compound_device}, {7'h00, m[0]});
      end
      chk({7'h00, hub_config.self_powered}, 8'h00);
      chk({7'h00, hub_config.full_speed_only}, 8'h00);
      chk({7'h00, hub_config.end_packet_suppress}, 8'h00);
      $display("config bytes done");
      i_host_loader.wr(OFS_DEVICE_RELEASE_HIGH, 8'hA5);
      i_host_loader.wr(OFS_FIXED_PORT, 8'hFF);
      i_host_loader.wr(OFS_PORT_OFF_SELF, 8'hFF);
      rchk(OFS_DEVICE_RELEASE_HIGH, 8'hA5);
      rchk(OFS_FIXED_PORT, 8'h06);
      rchk(OFS_PORT_OFF_SELF, 8'h06);
      chk(hub_config.device_release_high, 8'hA5);
      chk({6'h00, hub_config.fixed_port_flags}, 8'h03);
      chk({6'h00, hub_config.self_powered_port_off}, 8'h00);
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h80);
      cyc(1);
      chk({6'h00, hub_config.self_powered_port_off}, 8'h03);
      $display("port masks done");
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h00);
      i_host_loader.wr(OFS_POWER_SWITCH_B, 8'h80);
      local_power_sense_pin = 1'b1;
      cyc(8);
      chk({7'h00, hub_config.self_powered}, 8'h01);
      local_power_sense_pin = 1'b0;
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h80);
      cyc(8);
      chk({7'h00, hub_config.self_powered}, 8'h00);
      $display("dynamic power done");
      i_host_loader.wr(OFS_POWER_SWITCH_B, 8'h10);
      overcurrent_n_pin = 1'b0;
      cyc(60);
      chk({7'h00, overcurrent_fault}, 8'h00);
      cyc(40);
      chk({7'h00, overcurrent_fault}, 8'h01);
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h04);
      cyc(100);
      chk({7'h00, overcurrent_fault}, 8'h00);
      overcurrent_n_pin = 1'b1;
      $display("over-current done");
      i_host_loader.wr(OFS_STATUS_CMD, 8'h04);
      cyc(3);
      rchk(OFS_STATUS_CMD, 8'h00);
      rchk(OFS_DEVICE_RELEASE_HIGH, 8'h00);
      chk({6'h00, hub_config.fixed_port_flags}, 8'h00);
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h20);
      i_host_loader.wr(OFS_STATUS_CMD, 8'h03);
      i_host_loader.wr(OFS_POWER_SPEED_A, 8'h00);
      i_host_loader.wr(OFS_DEVICE_RELEASE_HIGH, 8'h11);
      rchk(OFS_POWER_SPEED_A, 8'h20);
      rchk(OFS_DEVICE_RELEASE_HIGH, 8'h00);
      rchk(OFS_STATUS_CMD, 8'h03);
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      cyc(1);
      chk({6'h00, config_lock, usb_attach}, 8'h00);
      $display("lock and soft reset done");
      close_out();
   end
endmodule
